//--- hdl/ucr_params.svh
// Register map, reset values and field positions of the quad channel bank
`ifndef UCR_PARAMS_SVH
`define UCR_PARAMS_SVH
// Address decode
`define UCR_GLB_BIT        9
`define UCR_CH_MSB         8
`define UCR_CH_LSB         7
`define UCR_IDX_MSB        6
`define UCR_IDX_LSB        2
`define UCR_NUM_REGS       21
// Per channel register indices, byte address = channel*0x80 + index*4
`define UCR_IDX_DIV_LOW    5'h00
`define UCR_IDX_DIV_HIGH   5'h01
`define UCR_IDX_HOLD       5'h02
`define UCR_IDX_INT_EN     5'h03
`define UCR_IDX_FIFO_CTL   5'h04
`define UCR_IDX_INT_SRC    5'h05
`define UCR_IDX_LINE_CTL   5'h06
`define UCR_IDX_MDM_CTL    5'h07
`define UCR_IDX_LINE_STAT  5'h08
`define UCR_IDX_MDM_STAT   5'h09
`define UCR_IDX_SCRATCH    5'h0a
`define UCR_IDX_ENH_MODE   5'h0b
`define UCR_IDX_FIFO_LVL   5'h0c
`define UCR_IDX_TRIG_LVL   5'h0d
`define UCR_IDX_FIFO_CNT   5'h0e
`define UCR_IDX_FEAT_CTL   5'h0f
`define UCR_IDX_ENH_FEAT   5'h10
`define UCR_IDX_RESUME1    5'h11
`define UCR_IDX_RESUME2    5'h12
`define UCR_IDX_PAUSE1     5'h13
`define UCR_IDX_PAUSE2     5'h14
// Global registers (address bit 9 set)
`define UCR_GIDX_FIFO_RDY  5'h00
`define UCR_GIDX_EVT_STAT  5'h01
`define UCR_GIDX_EVT_MASK  5'h02
// Reset values
`define UCR_RST_ZERO       8'h00
`define UCR_RST_ONES       8'hff
`define UCR_RST_INT_SRC    8'h01
`define UCR_RST_LINE_STAT  8'h60
// Fields
`define UCR_SRC_NONE       8'h01
`define UCR_SRC_MODEM      8'h00
`define UCR_SRC_RXDATA     8'h04
`define UCR_IE_RXDATA      0
`define UCR_IE_MODEM       3
`define UCR_FC_ENABLE      0
`define UCR_FC_RXCLR       1
`define UCR_LC_BREAK       6
`define UCR_MC_DTR         0
`define UCR_MC_RTS         1
`define UCR_MC_LOOP        4
`define UCR_EF_UNLOCK      4
`define UCR_ENH_IE_MASK    8'hf0
`define UCR_ENH_FC_MASK    8'h30
`define UCR_ENH_MC_MASK    8'he0
`define UCR_NO_MASK        8'h00
`define UCR_ALL_MASK       8'hff
`define UCR_LS_IDLE        8'h60
`define UCR_HSIZE_WORD     3'h2
`define UCR_HTRANS_NSEQ    1
`endif

//--- hdl/ucr_pkg.sv
// Types shared by the quad channel reset bank
package ucr_pkg;
   typedef logic [7:0] ucr_byte_t;
   typedef enum logic [0:0]
   {
      UCR_PH_ADDR = 1'b0,
      UCR_PH_DATA = 1'b1
   } ucr_phase_t;
endpackage

//--- hdl/ucr_channel_reset.sv
// Quad UART channel register bank with defined reset state, AHB-Lite slave
//------------------------------------------------------------------------
// What this block does
// - Divisor bytes and both holding bytes carry no reset value.
// - Interrupt enable, FIFO control, line and modem control clear at reset.
// - Interrupt source reads 0x01, nothing pending, after reset.
// - Line status reads 0x60 after reset, both transmit empty flags set.
// - Modem change bits clear at reset; upper bits show inverted inputs.
// - Scratchpad becomes all ones at reset.
// - Enhanced mode, levels, counts, feature and enhanced feature clear.
// - Both resume and both pause characters clear at reset.
// - FIFO ready status becomes all ones at reset.
// - Serial transmit idles high, infrared transmit low, during and after reset.
// - Request-to-send and terminal-ready outputs held high, deasserted.
// - Receive-ready output high, transmit-ready output low.
// - Outside alternate bus mode with select low, interrupt request stays high.
// - FIFO ready status: inverted transmit-ready low, receive-ready high nibble.
//------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "ucr_params.svh"

module ucr_channel_reset
   import ucr_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [3:0]  ctsN,
   input  wire logic [3:0]  dsrN,
   input  wire logic [3:0]  riN,
   input  wire logic [3:0]  dcdN,
   input  wire logic        busMode68,
   input  wire logic        interruptSelect,
   output logic      [3:0]  txOut,
   output logic      [3:0]  infraredTxOut,
   output logic      [3:0]  rtsN,
   output logic      [3:0]  dtrN,
   output logic      [3:0]  receiveReadyN,
   output logic      [3:0]  transmitReadyN,
   output logic      [3:0]  intOut,
   output logic             irqN,
   output logic             blkIrq
);

   //---------------------------------------------------------------------
   // Storage
   //---------------------------------------------------------------------
   ucr_phase_t  phase_q;
   logic        wrCap_q;
   logic        glbCap_q;
   logic [1:0]  chCap_q;
   logic [4:0]  idxCap_q;
   logic        hreadyout_q;
   logic [31:0] hrdata_q;
   ucr_byte_t   ctl_q     [0:3][0:`UCR_NUM_REGS-1];
   ucr_byte_t   divLow_q  [0:3];
   ucr_byte_t   divHigh_q [0:3];
   ucr_byte_t   rxHold_q  [0:3];
   ucr_byte_t   txHold_q  [0:3];
   ucr_byte_t   intSrc_q  [0:3];
   ucr_byte_t   lineStat_q[0:3];
   ucr_byte_t   fifoCnt_q [0:3];
   logic [3:0]  delta_q   [0:3];
   logic [3:0]  dataReady_q;
   logic [15:0] mdmSync1_q;
   logic [15:0] mdmSync2_q;
   logic [15:0] mdmPrev_q;
   logic [1:0]  modeSync1_q;
   logic [1:0]  modeSync2_q;
   ucr_byte_t   fifoRdy_q;
   ucr_byte_t   evtStat_q;
   ucr_byte_t   evtMask_q;
   logic [3:0]  txOut_q;
   logic [3:0]  infrared_tx_out_q;
   logic [3:0]  rtsN_q;
   logic [3:0]  dtrN_q;
   logic [3:0]  rxRdyN_q;
   logic [3:0]  txRdyN_q;
   logic [3:0]  intOut_q;
   logic        irqN_q;
   logic        blkIrq_q;

   logic        doWr;
   logic        doRd;
   logic        accept;
   ucr_byte_t   wByte;
   logic [3:0]  rxSet;
   logic [3:0]  rxClr;
   logic [3:0]  dSet      [0:3];
   logic [3:0]  dClr      [0:3];
   logic [3:0]  lvlNow    [0:3];
   logic [3:0]  lvlPrev   [0:3];
   logic [3:0]  pend;
   ucr_byte_t   rdVal;

   //---------------------------------------------------------------------
   // Bus slave: one wait state, always OKAY
   //---------------------------------------------------------------------
   assign accept = hsel & htrans[`UCR_HTRANS_NSEQ] & hready;
   assign doWr   = (phase_q == UCR_PH_DATA) & wrCap_q;
   assign doRd   = (phase_q == UCR_PH_DATA) & ~wrCap_q;
   assign wByte  = hwdata[7:0];

   // Address capture and answer timing
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         phase_q     <= UCR_PH_ADDR;
         wrCap_q     <= 1'b0;
         glbCap_q    <= 1'b0;
         chCap_q     <= 2'h0;
         idxCap_q    <= 5'h00;
         hreadyout_q <= 1'b1;
         hrdata_q    <= 32'h0000_0000;
      end
      else
      begin
         case (phase_q)
            UCR_PH_ADDR:
            begin
               if (accept)
               begin
                  phase_q     <= UCR_PH_DATA;
                  wrCap_q     <= hwrite & (hsize == `UCR_HSIZE_WORD);
                  glbCap_q    <= haddr[`UCR_GLB_BIT];
                  chCap_q     <= haddr[`UCR_CH_MSB:`UCR_CH_LSB];
                  idxCap_q    <= haddr[`UCR_IDX_MSB:`UCR_IDX_LSB];
                  hreadyout_q <= 1'b0;
               end
            end
            UCR_PH_DATA:
            begin
               phase_q     <= UCR_PH_ADDR;
               hreadyout_q <= 1'b1;
               hrdata_q    <= {24'h00_0000, rdVal};
            end
            default:
            begin
               phase_q     <= UCR_PH_ADDR;
               hreadyout_q <= 1'b1;
            end
         endcase
      end
   end

   assign hrdata    = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp     = 1'b0;

   //---------------------------------------------------------------------
   // Pin synchronisers
   //---------------------------------------------------------------------
   // Two stages, nothing looks at the first
   always_ff @(posedge ref_clk)
   begin
      mdmSync1_q  <= {dcdN, riN, dsrN, ctsN};
      mdmSync2_q  <= mdmSync1_q;
      mdmPrev_q   <= mdmSync2_q;
      modeSync1_q <= {interruptSelect, busMode68};
      modeSync2_q <= modeSync1_q;
   end

   function automatic logic [3:0] mdmLvl(input logic [15:0] s, input int c);
      return ~{s[12+c], s[8+c], s[4+c], s[c]};
   endfunction

   //---------------------------------------------------------------------
   // Writable control registers
   //---------------------------------------------------------------------
   function automatic ucr_byte_t rstVal(input int i);
      return (i == `UCR_IDX_SCRATCH) ? `UCR_RST_ONES : `UCR_RST_ZERO;
   endfunction

   function automatic logic ctlWritable(input logic [4:0] i);
      case (i)
         `UCR_IDX_INT_EN, `UCR_IDX_FIFO_CTL, `UCR_IDX_LINE_CTL,
         `UCR_IDX_MDM_CTL, `UCR_IDX_SCRATCH, `UCR_IDX_ENH_MODE,
         `UCR_IDX_TRIG_LVL, `UCR_IDX_FEAT_CTL, `UCR_IDX_ENH_FEAT,
         `UCR_IDX_RESUME1, `UCR_IDX_RESUME2, `UCR_IDX_PAUSE1,
         `UCR_IDX_PAUSE2:  return 1'b1;
         default:          return 1'b0;
      endcase
   endfunction

   // Enhanced bits are locked unless the unlock bit is set
   function automatic ucr_byte_t lockMask(input logic [4:0] i, input logic unl);
      if (unl)
         return `UCR_NO_MASK;
      case (i)
         `UCR_IDX_INT_EN:   return `UCR_ENH_IE_MASK;
         `UCR_IDX_FIFO_CTL: return `UCR_ENH_FC_MASK;
         `UCR_IDX_MDM_CTL:  return `UCR_ENH_MC_MASK;
         default:           return `UCR_NO_MASK;
      endcase
   endfunction

   // All channels load their defaults on the same edge
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         for (int c = 0; c < 4; c++)
            for (int i = 0; i < `UCR_NUM_REGS; i++)
               ctl_q[c][i] <= rstVal(i);
      end
      else if (doWr && !glbCap_q && ctlWritable(idxCap_q))
      begin
         ctl_q[chCap_q][idxCap_q] <=
            (ctl_q[chCap_q][idxCap_q] &
             lockMask(idxCap_q, ctl_q[chCap_q][`UCR_IDX_ENH_FEAT][`UCR_EF_UNLOCK])) |
            (wByte &
             ~lockMask(idxCap_q, ctl_q[chCap_q][`UCR_IDX_ENH_FEAT][`UCR_EF_UNLOCK]));
      end
   end

   // Data bytes keep whatever they held; reset leaves them alone
   always_ff @(posedge ref_clk)
   begin
      if (doWr && !glbCap_q)
      begin
         if (idxCap_q == `UCR_IDX_DIV_LOW)
            divLow_q[chCap_q] <= wByte;
         if (idxCap_q == `UCR_IDX_DIV_HIGH)
            divHigh_q[chCap_q] <= wByte;
         if (idxCap_q == `UCR_IDX_HOLD)
            txHold_q[chCap_q] <= wByte;
         if (idxCap_q == `UCR_IDX_HOLD && ctl_q[chCap_q][`UCR_IDX_MDM_CTL][`UCR_MC_LOOP])
            rxHold_q[chCap_q] <= wByte;
      end
   end

   //---------------------------------------------------------------------
   // Channel events
   //---------------------------------------------------------------------
   // Loopback data, receive clear, modem change detect
   always_comb
   begin
      for (int c = 0; c < 4; c++)
      begin
         rxSet[c] = doWr & ~glbCap_q & (chCap_q == c[1:0]) &
                    (idxCap_q == `UCR_IDX_HOLD) &
                    ctl_q[c][`UCR_IDX_MDM_CTL][`UCR_MC_LOOP];
         rxClr[c] = ~glbCap_q & (chCap_q == c[1:0]) &
                    ((doRd & (idxCap_q == `UCR_IDX_HOLD)) |
                     (doWr & (idxCap_q == `UCR_IDX_FIFO_CTL) & wByte[`UCR_FC_RXCLR]));
         lvlNow[c]  = mdmLvl(mdmSync2_q, c);
         lvlPrev[c] = mdmLvl(mdmPrev_q, c);
         dSet[c][0] = lvlNow[c][0] ^ lvlPrev[c][0];
         dSet[c][1] = lvlNow[c][1] ^ lvlPrev[c][1];
         dSet[c][2] = lvlPrev[c][2] & ~lvlNow[c][2]; // Trailing edge only
         dSet[c][3] = lvlNow[c][3] ^ lvlPrev[c][3];
         dClr[c]    = {4{doRd & ~glbCap_q & (chCap_q == c[1:0]) &
                        (idxCap_q == `UCR_IDX_MDM_STAT)}};
      end
   end

   // Sticky channel flags, a set beats a clear in the same cycle
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         dataReady_q <= 4'h0;
         for (int c = 0; c < 4; c++)
            delta_q[c] <= 4'h0;
      end
      else
      begin
         dataReady_q <= rxSet | (dataReady_q & ~rxClr);
         for (int c = 0; c < 4; c++)
            delta_q[c] <= dSet[c] | (delta_q[c] & ~dClr[c]);
      end
   end

   //---------------------------------------------------------------------
   // Status registers and pins
   //---------------------------------------------------------------------
   // Pending interrupt per channel from enables and flags
   always_comb
   begin
      for (int c = 0; c < 4; c++)
         pend[c] = (ctl_q[c][`UCR_IDX_INT_EN][`UCR_IE_MODEM] & (|delta_q[c])) |
                   (ctl_q[c][`UCR_IDX_INT_EN][`UCR_IE_RXDATA] & dataReady_q[c]);
   end

   // Source, line status, counts and output pins
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         for (int c = 0; c < 4; c++)
         begin
            intSrc_q[c]   <= `UCR_RST_INT_SRC;
            lineStat_q[c] <= `UCR_RST_LINE_STAT;
            fifoCnt_q[c]  <= `UCR_RST_ZERO;
         end
         txOut_q   <= 4'hf;
         infrared_tx_out_q    <= 4'h0;
         rtsN_q    <= 4'hf;
         dtrN_q    <= 4'hf;
         rxRdyN_q  <= 4'hf;
         txRdyN_q  <= 4'h0;
         fifoRdy_q <= `UCR_RST_ONES;
         intOut_q  <= 4'h0;
         irqN_q    <= 1'b1;
      end
      else
      begin
         for (int c = 0; c < 4; c++)
         begin
            if (ctl_q[c][`UCR_IDX_INT_EN][`UCR_IE_MODEM] && (|delta_q[c]))
               intSrc_q[c] <= `UCR_SRC_MODEM |
                              {{2{ctl_q[c][`UCR_IDX_FIFO_CTL][`UCR_FC_ENABLE]}}, 6'h00};
            else if (ctl_q[c][`UCR_IDX_INT_EN][`UCR_IE_RXDATA] && dataReady_q[c])
               intSrc_q[c] <= `UCR_SRC_RXDATA |
                              {{2{ctl_q[c][`UCR_IDX_FIFO_CTL][`UCR_FC_ENABLE]}}, 6'h00};
            else
               intSrc_q[c] <= `UCR_SRC_NONE |
                              {{2{ctl_q[c][`UCR_IDX_FIFO_CTL][`UCR_FC_ENABLE]}}, 6'h00};
            lineStat_q[c] <= `UCR_LS_IDLE | {7'h00, dataReady_q[c]};
            fifoCnt_q[c]  <= {7'h00, dataReady_q[c]};
            txOut_q[c]    <= ~ctl_q[c][`UCR_IDX_LINE_CTL][`UCR_LC_BREAK];
            rtsN_q[c]     <= ~ctl_q[c][`UCR_IDX_MDM_CTL][`UCR_MC_RTS];
            dtrN_q[c]     <= ~ctl_q[c][`UCR_IDX_MDM_CTL][`UCR_MC_DTR];
         end
         infrared_tx_out_q    <= 4'h0;
         rxRdyN_q  <= ~dataReady_q;
         txRdyN_q  <= 4'h0; // Holding byte leaves at once, space always free
         fifoRdy_q <= {~dataReady_q, 4'hf};
         intOut_q  <= pend & ~{4{modeSync2_q[0] & ~modeSync2_q[1]}};
         irqN_q    <= ~(modeSync2_q[0] & ~modeSync2_q[1] & (|pend));
      end
   end

   assign txOut          = txOut_q;
   assign infraredTxOut  = infrared_tx_out_q;
   assign rtsN           = rtsN_q;
   assign dtrN           = dtrN_q;
   assign receiveReadyN  = rxRdyN_q;
   assign transmitReadyN = txRdyN_q;
   assign intOut         = intOut_q;
   assign irqN           = irqN_q;

   //---------------------------------------------------------------------
   // Block interrupt: sticky events, mask, write one to clear
   //---------------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         evtStat_q <= 8'h00;
         evtMask_q <= 8'h00;
         blkIrq_q  <= 1'b0;
      end
      else
      begin
         evtStat_q <= {|dSet[3], |dSet[2], |dSet[1], |dSet[0], rxSet} |
                      (evtStat_q & ~((doWr && glbCap_q &&
                                      idxCap_q == `UCR_GIDX_EVT_STAT) ? wByte : 8'h00));
         if (doWr && glbCap_q && idxCap_q == `UCR_GIDX_EVT_MASK)
            evtMask_q <= wByte;
         blkIrq_q  <= |(evtStat_q & evtMask_q);
      end
   end

   assign blkIrq = blkIrq_q;

   //---------------------------------------------------------------------
   // Read multiplexer
   //---------------------------------------------------------------------
   always_comb
   begin
      rdVal = 8'h00;
      if (glbCap_q)
      begin
         case (idxCap_q)
            `UCR_GIDX_FIFO_RDY: rdVal = fifoRdy_q;
            `UCR_GIDX_EVT_STAT: rdVal = evtStat_q;
            `UCR_GIDX_EVT_MASK: rdVal = evtMask_q;
            default:            rdVal = 8'h00;
         endcase
      end
      else
      begin
         case (idxCap_q)
            `UCR_IDX_DIV_LOW:   rdVal = divLow_q[chCap_q];
            `UCR_IDX_DIV_HIGH:  rdVal = divHigh_q[chCap_q];
            `UCR_IDX_HOLD:      rdVal = rxHold_q[chCap_q];
            `UCR_IDX_INT_SRC:   rdVal = intSrc_q[chCap_q];
            `UCR_IDX_LINE_STAT: rdVal = lineStat_q[chCap_q];
            `UCR_IDX_MDM_STAT:  rdVal = {mdmLvl(mdmSync2_q, chCap_q), delta_q[chCap_q]};
            `UCR_IDX_FIFO_LVL,
            `UCR_IDX_FIFO_CNT:  rdVal = fifoCnt_q[chCap_q];
            `UCR_IDX_FIFO_CTL,
            `UCR_IDX_ENH_MODE,
            `UCR_IDX_TRIG_LVL:  rdVal = 8'h00;
            default:            rdVal = ctlWritable(idxCap_q) ?
                                        ctl_q[chCap_q][idxCap_q] : 8'h00;
         endcase
      end
   end

   //---------------------------------------------------------------------
   // Assertions
   //---------------------------------------------------------------------
   function automatic logic allEq(input int idx, input ucr_byte_t v);
      logic ok;
      ok = 1'b1;
      for (int c = 0; c < 4; c++)
         if (ctl_q[c][idx] != v)
            ok = 1'b0;
      return ok;
   endfunction

   sequence s_waitAns;
      !hreadyout ##1 hreadyout;
   endsequence

   a_bus_one_wait: assert property (@(posedge ref_clk) disable iff (!nrst)
      (accept && phase_q == UCR_PH_ADDR) |=> s_waitAns)
      else $error("bus answer not after one wait state");
   a_rst_ctl_zero: assert property (@(posedge ref_clk) !nrst |=>
      allEq(`UCR_IDX_INT_EN, 8'h00) && allEq(`UCR_IDX_FIFO_CTL, 8'h00) &&
      allEq(`UCR_IDX_LINE_CTL, 8'h00) && allEq(`UCR_IDX_MDM_CTL, 8'h00))
      else $error("control registers not cleared by reset");
   a_rst_src_none: assert property (@(posedge ref_clk) !nrst |=>
      intSrc_q[0] == 8'h01 && intSrc_q[3] == 8'h01)
      else $error("interrupt source not idle after reset");
   a_rst_line_idle: assert property (@(posedge ref_clk) !nrst |=>
      lineStat_q[0] == 8'h60 && lineStat_q[2] == 8'h60)
      else $error("line status not 0x60 after reset");
   a_rst_delta_clear: assert property (@(posedge ref_clk) !nrst |=>
      delta_q[0] == 4'h0 && delta_q[1] == 4'h0 && delta_q[3] == 4'h0)
      else $error("modem change bits not cleared by reset");
   a_rst_scratch_ones: assert property (@(posedge ref_clk) !nrst |=>
      allEq(`UCR_IDX_SCRATCH, 8'hff))
      else $error("scratchpad not all ones after reset");
   a_rst_enh_zero: assert property (@(posedge ref_clk) !nrst |=>
      allEq(`UCR_IDX_ENH_MODE, 8'h00) && allEq(`UCR_IDX_TRIG_LVL, 8'h00) &&
      allEq(`UCR_IDX_FEAT_CTL, 8'h00) && allEq(`UCR_IDX_ENH_FEAT, 8'h00) &&
      fifoCnt_q[1] == 8'h00)
      else $error("enhanced registers not cleared by reset");
   a_rst_flow_chars: assert property (@(posedge ref_clk) !nrst |=>
      allEq(`UCR_IDX_RESUME1, 8'h00) && allEq(`UCR_IDX_RESUME2, 8'h00) &&
      allEq(`UCR_IDX_PAUSE1, 8'h00) && allEq(`UCR_IDX_PAUSE2, 8'h00))
      else $error("flow characters not cleared by reset");
   a_rst_ready_ones: assert property (@(posedge ref_clk) !nrst |=>
      fifoRdy_q == 8'hff)
      else $error("fifo ready status not all ones after reset");
   a_rst_tx_idle: assert property (@(posedge ref_clk) !nrst [*2] |->
      txOut == 4'hf && infraredTxOut == 4'h0)
      else $error("transmit pins not idle in reset");
   a_rst_modem_pins: assert property (@(posedge ref_clk) !nrst |=>
      rtsN == 4'hf && dtrN == 4'hf)
      else $error("modem outputs not deasserted in reset");
   a_rst_ready_pins: assert property (@(posedge ref_clk) !nrst |=>
      receiveReadyN == 4'hf && transmitReadyN == 4'h0)
      else $error("ready pins wrong in reset");
   a_irq_held_high: assert property (@(posedge ref_clk)
      (!nrst || pend == 4'h0) |=> irqN)
      else $error("interrupt request low with nothing pending");
   a_ready_mirror: assert property (@(posedge ref_clk) disable iff (!nrst)
      fifoRdy_q == {receiveReadyN, ~transmitReadyN})
      else $error("fifo ready status does not mirror ready pins");
   a_rst_all_chan: assert property (@(posedge ref_clk) $rose(nrst) |->
      allEq(`UCR_IDX_SCRATCH, 8'hff) && allEq(`UCR_IDX_LINE_CTL, 8'h00) &&
      dataReady_q == 4'h0)
      else $error("channels not all at reset state on release");

endmodule // ucr_channel_reset

`default_nettype wire

//--- verif/ucr_host_model.sv
// Host processor model: AHB-Lite master issuing single word transfers
`timescale 1ns/1ps
`default_nettype none
module ucr_host_model
(
   input  wire logic        ref_clk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic      [31:0] haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [2:0]  hsize,
   output logic      [31:0] hwdata
);
   // Idle bus from time zero
   initial
   begin
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = '0;
   end
   // Wait for hready high at a rising edge, keeping read data seen there
   task automatic waitReady(output logic [31:0] q, output bit to);
      int n;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (hready !== 1'b1 && n < 40);
      q = hrdata;
      to = (hready !== 1'b1);
   endtask
   // Address phase held until taken, then data phase held until done
   task automatic xfer(input logic wr, input logic [31:0] a, wd,
                       output logic [31:0] rd, output bit to);
      bit t0;
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      waitReady(rd, t0);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      waitReady(rd, to);
      to = to | t0;
   endtask
endmodule // ucr_host_model
`default_nettype wire

//--- verif/ucr_channel_reset_tb.sv
// Self-checking bench for the quad channel reset bank
`timescale 1ns/1ps
`default_nettype none
module ucr_channel_reset_tb;
   logic        ref_clk, nrst, busMode68, interruptSelect, hsel, hwrite, hready;
   logic        hresp, irqN, blkIrq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [3:0]  ctsN, dsrN, riN, dcdN, txOut, infraredTxOut, rtsN, dtrN;
   logic [3:0]  receiveReadyN, transmitReadyN, intOut;
   int          nFail, checks;

   ucr_channel_reset dut (.ref_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .ctsN, .dsrN, .riN,
      .dcdN, .busMode68, .interruptSelect, .txOut, .infraredTxOut, .rtsN, .dtrN,
      .receiveReadyN, .transmitReadyN, .intOut, .irqN, .blkIrq);
   ucr_host_model host (.ref_clk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata);

   // 125 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic finalReport();
      $display("checks %0d mismatches %0d", checks, nFail);
      if (nFail == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         nFail++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, wd, output logic [31:0] rd);
      bit to;
      host.xfer(wr, a, wd, rd, to);
      if (to)
      begin
         nFail++;
         finalReport();
      end
   endtask
   task automatic rdchk(input string what, input logic [31:0] a, exp);
      logic [31:0] rd;
      bus(1'b0, a, 32'h0, rd);
      chk(what, rd, exp);
   endtask
   // Output pins against their idle levels, sampled mid-cycle
   task automatic pins();
      @(negedge ref_clk);
      chk("txOut", txOut, 32'hf);
      chk("infraredTxOut", infraredTxOut, 32'h0);
      chk("rtsN dtrN", {rtsN, dtrN}, 32'hff);
      chk("ready pins", {receiveReadyN, transmitReadyN}, 32'hf0);
      chk("irq pins", {intOut, irqN, blkIrq, hresp}, 32'h04);
      @(posedge ref_clk);
   endtask
   task automatic doReset();
      nrst <= 1'b0;
      repeat (8) @(posedge ref_clk);
      pins();
      nrst <= 1'b1;
      pins();
      pins();
   endtask
   // Every register from interrupt enable up of every channel, one unmapped offset, then the ready status
   task automatic regs();
      logic [7:0] e;
      for (int ch = 0; ch < 4; ch++)
         for (int i = 3; i < 22; i++)
         begin
            e = (i == 5) ? 8'h01 : (i == 8) ? 8'h60 : (i == 10) ? 8'hff : 8'h00;
            if (i == 9)
               e = {~dcdN[ch], ~riN[ch], ~dsrN[ch], ~ctsN[ch], 4'h0};
            rdchk("register", ch * 128 + i * 4, {24'h0, e});
         end
      rdchk("fifo ready", 32'h200, 32'hff);
   endtask
   // Dirty every channel, reset again in mid-run in alternate bus mode
   task automatic writeThenReset();
      logic [31:0] rd;
      for (int ch = 0; ch < 4; ch++)
         for (int i = 6; i < 21; i++)
            if (i != 8 && i != 9 && i != 16)
               bus(1'b1, ch * 128 + i * 4, (i == 7) ? 32'h03 : 32'h5a, rd);
      rdchk("scratchpad", 32'h28, 32'h5a);
      @(negedge ref_clk);
      chk("active pins", {txOut, rtsN, dtrN}, 32'h0);
      @(posedge ref_clk);
      busMode68 <= 1'b1;
      doReset();
      regs();
      $display("test write then reset done");
   endtask
   // Loopback data event, masking, clearing, and a modem change masked from the block interrupt
   task automatic events();
      logic [31:0] rd;
      bus(1'b1, 32'h1c, 32'h10, rd);
      bus(1'b1, 32'h08, 32'h3c, rd);
      bus(1'b1, 32'h208, 32'h01, rd);
      rdchk("fifo ready", 32'h200, 32'hef);
      rdchk("event status", 32'h204, 32'h01);
      repeat (2) @(negedge ref_clk);
      chk("blkIrq set", {blkIrq, receiveReadyN}, 32'h1e);
      @(posedge ref_clk);
      bus(1'b1, 32'h204, 32'h01, rd);
      bus(1'b1, 32'h8c, 32'h08, rd);
      ctsN[1] <= 1'b1;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("irq asserted", {intOut, irqN}, 32'h0);
      @(posedge ref_clk);
      rdchk("event status", 32'h204, 32'h20);
      rdchk("modem status", 32'ha4, {24'h0, ~dcdN[1], ~riN[1], ~dsrN[1], 5'h01});
      @(negedge ref_clk);
      chk("blkIrq masked", {blkIrq, irqN}, 32'h1);
      @(posedge ref_clk);
      $display("test events done");
   endtask

   initial
   begin
      nrst = 1'b0;
      busMode68 = 1'b0;
      interruptSelect = 1'b0;
      ctsN = 4'h5;
      dsrN = 4'h3;
      riN = 4'hf;
      dcdN = 4'ha;
      nFail = 0;
      checks = 0;
      @(posedge ref_clk);
      doReset();
      regs();
      $display("test reset state done");
      writeThenReset();
      events();
      finalReport();
   end
endmodule // ucr_channel_reset_tb
`default_nettype wire
